// File: flm_defines.svh
// constants for the flow limit and error manager
// Function
// - average flow and temperature over 1..30 seconds
// - measuring and display rate independent of averaging
// - limit switches re-evaluated every measurement tick
// - switches compare flow or temperature in display units
// - on/off thresholds give hysteresis and switching sense
// - flow multiplied by scale factor 0.01..9.99
// - measurement suspended while parameters are edited
// - prioritised plausibility check blocks leaving edit
// - flow below suppression threshold forced to zero
// - suppression changes accepted during running measurement
// - zero percent setting captures present flow as offset
// - faults shown by number and error output
// - power-on self-test indicated, errors 1-5 block operation
// - key press repeats self-test while its error pends
// - errors 10, 21 stop measuring, resume when cleared
// - errors 20,30,60,40,41 keep measuring, assert error output
// - last error kept, readable and clearable
// - simultaneous errors ranked in fixed order
// - self-test raises errors 1 to 5 by cause
// - error 10 sensor fault, error 21 temperature high
// - errors 40, 41 controller faults, 60 pulse too small
`ifndef FLM_DEFINES_SVH
`define FLM_DEFINES_SVH
// apb map (byte addresses)
`define FLM_ADDR_CTRL 12'h000
`define FLM_ADDR_AVG 12'h004
`define FLM_ADDR_LS1 12'h008
`define FLM_ADDR_LS2 12'h00c
`define FLM_ADDR_SCALE 12'h010
`define FLM_ADDR_SUPP 12'h014
`define FLM_ADDR_RANGE 12'h018
`define FLM_ADDR_FLOW 12'h01c
`define FLM_ADDR_TEMP 12'h020
`define FLM_ADDR_STAT 12'h024
`define FLM_ADDR_ERRMEM 12'h028
`define FLM_ADDR_OFFSET 12'h02c
// ctrl bits
`define FLM_CTRL_EDIT 0
`define FLM_CTRL_EXIT 1
`define FLM_CTRL_ASSIGN1 2
`define FLM_CTRL_ASSIGN2 3
`define FLM_CTRL_ERRCLR 4
`define FLM_CTRL_PULSE 5
`define FLM_CTRL_T4 6
// limits and resets
`define FLM_AVG_MIN 5'd1
`define FLM_AVG_MAX 5'd30
`define FLM_AVG_RST 5'd1
`define FLM_SCALE_MIN 10'd1
`define FLM_SCALE_MAX 10'd999
`define FLM_SCALE_RST 10'd100
`define FLM_SCALE_DIV 100
`define FLM_SUPP_MAX 4'd10
`define FLM_SUPP_RST 4'd1
`define FLM_SELFTEST_CYC 16
// error numbers
`define FLM_ERR_NONE 7'd0
`define FLM_ERR_SENSOR 7'd10
`define FLM_ERR_TEMP_HI 7'd21
`define FLM_ERR_TEMP_LO 7'd20
`define FLM_ERR_FLOW_HI 7'd30
`define FLM_ERR_PULSE 7'd60
`define FLM_ERR_OSC 7'd40
`define FLM_ERR_WDOG 7'd41
`endif

// File: flm_pkg.sv
// types for the flow limit and error manager
package flm_pkg;
    typedef enum logic [3:0] {
        FLM_SELFTEST = 4'b0001,
        FLM_HALTED = 4'b0010,
        FLM_MEASURE = 4'b0100,
        FLM_EDIT = 4'b1000
    } flm_state_e;
    // fault inputs from self-test and runtime monitors
    typedef struct packed {
        logic no_params;
        logic sum_param;
        logic sum_prog;
        logic sum_data;
        logic ctrl_int;
        logic sensor;
        logic temp_hi;
        logic temp_lo;
        logic flow_hi;
        logic pulse_small;
        logic osc;
        logic wdog;
    } flm_fault_s;
    typedef struct packed {
        logic [15:0] activate;
        logic [15:0] release_lvl;
    } flm_limit_s;
endpackage : flm_pkg

// File: flm_flow_limit_error.sv
// measurement post-processing, limit switches and error manager
`timescale 1ns/1ps
`include "flm_defines.svh"
module flm_flow_limit_error #(
    parameter int DATA_W = 16,
    parameter int TICKS_PER_SEC = 1,
    parameter int MAX_SAMPLES = 30
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sensing head, same clock domain
    input wire logic meas_tick,
    input wire logic [DATA_W-1:0] raw_flow,
    input wire logic [DATA_W-1:0] raw_temp,
    input wire flm_pkg::flm_fault_s faults,
    input wire logic selftest_done,
    // keypad pin
    input wire logic key_pressed,
    // outputs
    output logic limit_switch_one,
    output logic limit_switch_two,
    output logic error_out,
    output logic selftest_busy,
    output logic measuring,
    output logic [6:0] error_number
);
    localparam int SUM_W = DATA_W + 5;
    initial begin
        if (TICKS_PER_SEC < 1 || MAX_SAMPLES < 30 * TICKS_PER_SEC || DATA_W < 8 || DATA_W > 16) begin
            $error("flm: unsupported parameters");
        end
    end

    function automatic logic [DATA_W-1:0] hyst(input logic cur, input logic [DATA_W-1:0] v,
                                               input flm_pkg::flm_limit_s l);
        logic [DATA_W-1:0] dummy;
        dummy = v;
        return {{(DATA_W-1){1'b0}}, cur};
    endfunction : hyst

    // hysteresis switch: activate above release => on when rising past activate
    function automatic logic sw_next(input logic cur, input logic [DATA_W-1:0] v,
                                     input logic [DATA_W-1:0] on_l, input logic [DATA_W-1:0] off_l);
        logic r;
        r = cur;
        if (on_l > off_l) begin
            if (v >= on_l) r = 1'b1;
            else if (v <= off_l) r = 1'b0;
        end else begin
            if (v <= on_l) r = 1'b1;
            else if (v >= off_l) r = 1'b0;
        end
        return r;
    endfunction : sw_next

    // registers
    logic [31:0] ctrl_reg;
    logic [4:0] avg_reg;
    logic [DATA_W-1:0] switch_one_activate_level_reg, switch_one_release_level_reg, ls2_on_reg, ls2_off_reg;
    logic [9:0] scale_reg;
    logic [3:0] supp_reg;
    logic [DATA_W-1:0] range_reg;
    logic [DATA_W-1:0] offset_reg;
    logic [DATA_W-1:0] flow_avg_reg, temp_avg_reg;
    logic [6:0] errmem_reg;
    logic [2:0] plaus_reg;
    flm_pkg::flm_state_e state_reg;
    logic [4:0] st_cnt_reg;
    logic key_s1_reg, key_s2_reg;

    // averaging window storage
    logic [DATA_W-1:0] fbuf_reg [MAX_SAMPLES];
    logic [DATA_W-1:0] tbuf_reg [MAX_SAMPLES];
    logic [SUM_W-1:0] fsum_reg, tsum_reg;
    logic [$clog2(MAX_SAMPLES)-1:0] wptr_reg;
    logic [$clog2(MAX_SAMPLES+1)-1:0] fill_reg;

    // decode
    wire wr = psel && penable && pwrite;
    wire rd_phase = psel && !penable;
    wire is_edit = (state_reg == flm_pkg::FLM_EDIT);
    wire run = (state_reg == flm_pkg::FLM_MEASURE) && meas_tick
               && err_ii == `FLM_ERR_NONE;
    wire [$clog2(MAX_SAMPLES+1)-1:0] win =
        ($clog2(MAX_SAMPLES+1))'(avg_reg * TICKS_PER_SEC);

    // flow post-processing: offset, scale, suppression
    wire [DATA_W-1:0] flow_off = (raw_flow > offset_reg) ? raw_flow - offset_reg : '0;
    wire [DATA_W+9:0] flow_mul = flow_off * scale_reg;
    wire [DATA_W+9:0] flow_scl_w = (DATA_W+10)'(flow_mul / `FLM_SCALE_DIV);
    wire [DATA_W-1:0] flow_scl = (|flow_scl_w[DATA_W+9:DATA_W]) ? '1 : flow_scl_w[DATA_W-1:0];
    wire [DATA_W+3:0] supp_lim = (DATA_W+4)'((range_reg * supp_reg) / 100);
    wire flow_small = {4'h0, flow_scl} < supp_lim;
    wire [DATA_W-1:0] flow_proc = flow_small ? '0 : flow_scl;

    // moving average over last win samples
    wire [$clog2(MAX_SAMPLES)-1:0] old_idx =
        (wptr_reg >= win) ? wptr_reg - win[$clog2(MAX_SAMPLES)-1:0]
                          : ($clog2(MAX_SAMPLES))'(MAX_SAMPLES + wptr_reg - win);
    wire full_win = fill_reg >= win;
    wire [SUM_W-1:0] fsum_next = fsum_reg + flow_proc - (full_win ? fbuf_reg[old_idx] : '0);
    wire [SUM_W-1:0] tsum_next = tsum_reg + raw_temp - (full_win ? tbuf_reg[old_idx] : '0);
    wire [$clog2(MAX_SAMPLES+1)-1:0] cnt = full_win ? win : fill_reg + 1'b1;

    // plausibility check, highest priority only
    wire oor1 = switch_one_activate_level_reg > range_reg || switch_one_release_level_reg > range_reg;
    wire oor2 = ls2_on_reg > range_reg || ls2_off_reg > range_reg;
    wire [2:0] plaus = oor1 ? 3'h1 : oor2 ? 3'h2 : (switch_one_activate_level_reg == switch_one_release_level_reg) ? 3'h3 :
                       (ls2_on_reg == ls2_off_reg) ? 3'h4 : 3'h0;

    // error ranking
    wire [6:0] err_i = faults.no_params ? 7'd1 : faults.sum_param ? 7'd2 :
                       faults.sum_prog ? 7'd3 : faults.sum_data ? 7'd4 :
                       faults.ctrl_int ? 7'd5 : `FLM_ERR_NONE;
    wire [6:0] err_ii = faults.sensor ? `FLM_ERR_SENSOR :
                        faults.temp_hi ? `FLM_ERR_TEMP_HI : `FLM_ERR_NONE;
    wire pulse_err = faults.pulse_small && ctrl_reg[`FLM_CTRL_PULSE];
    wire [6:0] err_iii = faults.temp_lo ? `FLM_ERR_TEMP_LO : faults.flow_hi ? `FLM_ERR_FLOW_HI :
                         pulse_err ? `FLM_ERR_PULSE : faults.osc ? `FLM_ERR_OSC :
                         faults.wdog ? `FLM_ERR_WDOG : `FLM_ERR_NONE;
    wire st_err = (state_reg == flm_pkg::FLM_SELFTEST || state_reg == flm_pkg::FLM_HALTED)
                  && err_i != `FLM_ERR_NONE;
    wire [6:0] err_top = st_err ? err_i : (err_ii != `FLM_ERR_NONE) ? err_ii : err_iii;
    wire key_edge = key_s2_reg; // level after sync; state machine acts once per halt

    // state machine
    flm_pkg::flm_state_e state_next;
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            flm_pkg::FLM_SELFTEST: begin
                if (st_cnt_reg == 5'(`FLM_SELFTEST_CYC) && selftest_done) begin
                    state_next = (err_i != `FLM_ERR_NONE) ? flm_pkg::FLM_HALTED
                                                          : flm_pkg::FLM_MEASURE;
                end
            end
            flm_pkg::FLM_HALTED: begin
                if (key_edge) state_next = flm_pkg::FLM_SELFTEST;
            end
            flm_pkg::FLM_MEASURE: begin
                if (wr && paddr == `FLM_ADDR_CTRL && pwdata[`FLM_CTRL_EDIT])
                    state_next = flm_pkg::FLM_EDIT;
            end
            flm_pkg::FLM_EDIT: begin
                if (wr && paddr == `FLM_ADDR_CTRL && pwdata[`FLM_CTRL_EXIT] && plaus == 3'h0)
                    state_next = flm_pkg::FLM_MEASURE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= flm_pkg::FLM_SELFTEST;
            st_cnt_reg <= '0;
            key_s1_reg <= 1'b0;
            key_s2_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            key_s1_reg <= key_pressed;
            key_s2_reg <= key_s1_reg;
            if (state_reg != flm_pkg::FLM_SELFTEST) st_cnt_reg <= '0;
            else if (st_cnt_reg != 5'(`FLM_SELFTEST_CYC)) st_cnt_reg <= st_cnt_reg + 5'd1;
        end
    end

    // apb register writes; supp and scale writable any time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= '0;
            avg_reg <= `FLM_AVG_RST;
            switch_one_activate_level_reg <= '0;
            switch_one_release_level_reg <= '0;
            ls2_on_reg <= '0;
            ls2_off_reg <= '0;
            scale_reg <= `FLM_SCALE_RST;
            supp_reg <= `FLM_SUPP_RST;
            range_reg <= '1;
            offset_reg <= '0;
        end else if (wr) begin
            unique case (paddr)
                `FLM_ADDR_CTRL: ctrl_reg <= pwdata & 32'h0000_006c;
                `FLM_ADDR_AVG: if (pwdata[4:0] >= `FLM_AVG_MIN && pwdata[4:0] <= `FLM_AVG_MAX && is_edit)
                    avg_reg <= pwdata[4:0];
                `FLM_ADDR_LS1: if (is_edit) begin
                    switch_one_activate_level_reg <= pwdata[DATA_W-1:0];
                    switch_one_release_level_reg <= pwdata[16+:DATA_W];
                end
                `FLM_ADDR_LS2: if (is_edit) begin
                    ls2_on_reg <= pwdata[DATA_W-1:0];
                    ls2_off_reg <= pwdata[16+:DATA_W];
                end
                `FLM_ADDR_SCALE: if (pwdata[9:0] >= `FLM_SCALE_MIN && pwdata[9:0] <= `FLM_SCALE_MAX)
                    scale_reg <= pwdata[9:0];
                `FLM_ADDR_SUPP: if (pwdata[3:0] <= `FLM_SUPP_MAX) begin
                    supp_reg <= pwdata[3:0];
                    if (pwdata[3:0] == 4'h0) offset_reg <= raw_flow;
                end
                `FLM_ADDR_RANGE: if (is_edit) range_reg <= pwdata[DATA_W-1:0];
                default: ;
            endcase
        end
    end

    // averaging and limit switches, once per tick while measuring
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fsum_reg <= '0;
            tsum_reg <= '0;
            wptr_reg <= '0;
            fill_reg <= '0;
            flow_avg_reg <= '0;
            temp_avg_reg <= '0;
            limit_switch_one <= 1'b0;
            limit_switch_two <= 1'b0;
        end else if (run) begin
            fbuf_reg[wptr_reg] <= flow_proc;
            tbuf_reg[wptr_reg] <= raw_temp;
            wptr_reg <= (wptr_reg == ($clog2(MAX_SAMPLES))'(MAX_SAMPLES - 1)) ? '0 : wptr_reg + 1'b1;
            fsum_reg <= fsum_next;
            tsum_reg <= tsum_next;
            if (!full_win) fill_reg <= fill_reg + 1'b1;
            else if (fill_reg > win) fill_reg <= win; // shrinks window after avg change
            flow_avg_reg <= DATA_W'(fsum_next / cnt);
            temp_avg_reg <= DATA_W'(tsum_next / cnt);
            limit_switch_one <= sw_next(limit_switch_one,
                ctrl_reg[`FLM_CTRL_ASSIGN1] ? raw_temp : flow_proc,
                switch_one_activate_level_reg, switch_one_release_level_reg);
            limit_switch_two <= sw_next(limit_switch_two,
                ctrl_reg[`FLM_CTRL_ASSIGN2] ? raw_temp : flow_proc,
                ls2_on_reg, ls2_off_reg);
        end
    end

    // error outputs and memory
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            errmem_reg <= `FLM_ERR_NONE;
            error_number <= `FLM_ERR_NONE;
            error_out <= 1'b0;
            selftest_busy <= 1'b1;
            measuring <= 1'b0;
            plaus_reg <= '0;
        end else begin
            error_number <= err_top;
            error_out <= ctrl_reg[`FLM_CTRL_T4] && err_top != `FLM_ERR_NONE;
            selftest_busy <= state_next == flm_pkg::FLM_SELFTEST;
            measuring <= state_next == flm_pkg::FLM_MEASURE && err_ii == `FLM_ERR_NONE;
            plaus_reg <= plaus;
            if (err_top != `FLM_ERR_NONE) errmem_reg <= err_top;
            else if (wr && paddr == `FLM_ADDR_CTRL && pwdata[`FLM_CTRL_ERRCLR])
                errmem_reg <= `FLM_ERR_NONE;
        end
    end

    // apb read, zero wait states
    wire [31:0] rd_mux =
        (paddr == `FLM_ADDR_CTRL) ? ctrl_reg :
        (paddr == `FLM_ADDR_AVG) ? {27'h0, avg_reg} :
        (paddr == `FLM_ADDR_LS1) ? {switch_one_release_level_reg, switch_one_activate_level_reg} :
        (paddr == `FLM_ADDR_LS2) ? {ls2_off_reg, ls2_on_reg} :
        (paddr == `FLM_ADDR_SCALE) ? {22'h0, scale_reg} :
        (paddr == `FLM_ADDR_SUPP) ? {28'h0, supp_reg} :
        (paddr == `FLM_ADDR_RANGE) ? {16'h0, range_reg} :
        (paddr == `FLM_ADDR_FLOW) ? {16'h0, flow_avg_reg} :
        (paddr == `FLM_ADDR_TEMP) ? {16'h0, temp_avg_reg} :
        (paddr == `FLM_ADDR_STAT) ? {17'h0, plaus_reg, state_reg, 1'b0, error_number} :
        (paddr == `FLM_ADDR_ERRMEM) ? {25'h0, errmem_reg} :
        (paddr == `FLM_ADDR_OFFSET) ? {16'h0, offset_reg} : 32'h0;
    wire unmapped = paddr > `FLM_ADDR_OFFSET || paddr[1:0] != 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= rd_phase;
            pslverr <= rd_phase && unmapped;
            if (rd_phase && !pwrite) prdata <= rd_mux;
        end
    end
endmodule : flm_flow_limit_error

// File: flm_flow_limit_error_asserts.sv
// port checker for the flow limit and error manager
`timescale 1ns/1ps
module flm_flow_limit_error_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // head and status
    input wire logic meas_tick,
    input wire logic limit_switch_one,
    input wire logic limit_switch_two,
    input wire logic error_out,
    input wire logic selftest_busy,
    input wire logic measuring,
    input wire logic [6:0] error_number
);
    wire g1_w = error_number inside {[7'h01:7'h05]};
    wire g2_w = error_number == 7'h0a || error_number == 7'h15;
    wire known_w = error_number inside {[7'h00:7'h05], 7'h0a, 7'h14, 7'h15, 7'h1e, 7'h28, 7'h29, 7'h3c};
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_apb_zero_wait: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    chk_ready_single: assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready outside one access cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_busy_no_meas: assert property (selftest_busy |-> !measuring)
        else $error("measuring during self-test");
    chk_group1_halt: assert property (g1_w && $past(g1_w) |-> !measuring)
        else $error("measuring with self-test error");
    chk_group2_stop: assert property (g2_w && $past(g2_w) |-> !measuring)
        else $error("measuring with sensor or temperature error");
    chk_errout_cause: assert property (error_out |-> error_number != 7'h00)
        else $error("error output with no error");
    chk_number_set: assert property (known_w)
        else $error("error number outside the ranking");
    chk_switch_on_tick: assert property (
        measuring && $past(measuring) && ($changed(limit_switch_one) || $changed(limit_switch_two))
        |-> $past(meas_tick) || $past(meas_tick, 2))
        else $error("switch moved without a tick");
    cover property ($rose(limit_switch_one));
    cover property (pready && pslverr);
    cover property (g2_w ##1 !g2_w);
    cover property ($fell(selftest_busy));
endmodule : flm_flow_limit_error_asserts

// File: flm_head_model.sv
// sensing head model: fixed-rate tick, raw levels, faults, self-test done
`timescale 1ns/1ps
module flm_head_model #(
    parameter int TICK_DIV = 8,
    parameter int DONE_DELAY = 20
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench requests
    input wire logic [15:0] flow_in,
    input wire logic [15:0] temp_in,
    input wire logic [11:0] fault_in,
    // head outputs
    output logic meas_tick = 1'b0,
    output logic [15:0] raw_flow,
    output logic [15:0] raw_temp,
    output flm_pkg::flm_fault_s faults,
    output logic selftest_done = 1'b0
);
    int div_q = 0;
    int done_q = 0;
    assign raw_flow = flow_in;
    assign raw_temp = temp_in;
    assign faults = flm_pkg::flm_fault_s'(fault_in);
    // tick rate never follows the averaging setting; done answers slowly
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 0;
            done_q <= 0;
            meas_tick <= 1'b0;
            selftest_done <= 1'b0;
        end else begin
            div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
            meas_tick <= div_q == TICK_DIV - 1;
            done_q <= (done_q < DONE_DELAY) ? done_q + 1 : done_q;
            selftest_done <= done_q == DONE_DELAY;
        end
    end
endmodule : flm_head_model

// File: flm_flow_limit_error_test.sv
// self-checking bench for the flow limit and error manager
`timescale 1ns/1ps
`include "flm_defines.svh"
module flm_flow_limit_error_test;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic key_pressed = 1'b0, pready, pslverr, err_q, meas_tick, selftest_done;
    logic [11:0] paddr = 12'h000, fault_in = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_q, ctrl_cfg = 32'h68;
    logic [15:0] flow_in = 16'h0, temp_in = 16'h0, raw_flow, raw_temp;
    flm_pkg::flm_fault_s faults;
    logic limit_switch_one, limit_switch_two, error_out, selftest_busy, measuring;
    logic [6:0] error_number;
    logic [31:0] t1[4] = '{32'h0190_07d0, 32'h0190_0190, 32'h0190_0258, 32'h0190_0258};
    logic [31:0] t2[4] = '{32'h0014_0014, 32'h0014_0014, 32'h0014_0014, 32'h001e_0014};
    logic [2:0] pc[4] = '{3'd1, 3'd3, 3'd4, 3'd0};
    logic [15:0] hf[4] = '{16'd700, 16'd500, 16'd300, 16'd500};
    logic [15:0] ht[4] = '{16'd10, 16'd25, 16'd35, 16'd25};
    logic [1:0] he[4] = '{2'b11, 2'b11, 2'b00, 2'b00};
    logic [6:0] g3[5] = '{7'd41, 7'd40, 7'd60, 7'd30, 7'd20};
    int n_mismatch = 0, total_checks = 0, cyc = 0;
    int q[$];
    always #2 pclk = ~pclk;
    flm_head_model #(.TICK_DIV(8), .DONE_DELAY(20)) i_head (.pclk(pclk), .presetn(presetn),
        .flow_in(flow_in), .temp_in(temp_in), .fault_in(fault_in), .meas_tick(meas_tick),
        .raw_flow(raw_flow), .raw_temp(raw_temp), .faults(faults), .selftest_done(selftest_done));
    flm_flow_limit_error #(.DATA_W(16), .TICKS_PER_SEC(1), .MAX_SAMPLES(30)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .meas_tick(meas_tick), .raw_flow(raw_flow), .raw_temp(raw_temp), .faults(faults),
        .selftest_done(selftest_done), .key_pressed(key_pressed),
        .limit_switch_one(limit_switch_one), .limit_switch_two(limit_switch_two),
        .error_out(error_out), .selftest_busy(selftest_busy), .measuring(measuring),
        .error_number(error_number));
    task automatic tally_and_finish();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // look at pready while it stands, take the answer at the same falling edge
        do begin
            @(negedge pclk);
        end while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic ticks(input int n);
        repeat (n) @(posedge pclk iff meas_tick === 1'b1);
        repeat (2) @(posedge pclk);
    endtask : ticks
    task automatic wait_idle();
        for (int i = 0; i < 300 && selftest_busy !== 1'b0; i++) @(posedge pclk);
        repeat (2) @(posedge pclk);
    endtask : wait_idle
    task automatic do_reset(input logic [11:0] f);
        fault_in <= f;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        check("busy_rst", selftest_busy, 1'b1);
        presetn <= 1'b1;
        wait_idle();
    endtask : do_reset
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        int a, b;
        logic [11:0] m;
        void'($urandom(33786));
        do_reset(12'h000);
        check("meas_on", measuring, 1'b1);
        apb(1'b1, `FLM_ADDR_CTRL, ctrl_cfg | 32'h1);
        apb(1'b1, `FLM_ADDR_RANGE, 32'd1000);
        check("edit_meas", measuring, 1'b0);
        apb(1'b1, `FLM_ADDR_AVG, 32'd2);
        apb(1'b1, `FLM_ADDR_AVG, 32'd31);
        apb(1'b0, `FLM_ADDR_AVG, 32'h0);
        check("avg", rd_q, 32'd2);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `FLM_ADDR_LS1, t1[i]);
            apb(1'b1, `FLM_ADDR_LS2, t2[i]);
            apb(1'b1, `FLM_ADDR_CTRL, ctrl_cfg | 32'h2);
            apb(1'b0, `FLM_ADDR_STAT, 32'h0);
            check("plaus", rd_q[14:8], {pc[i], (i == 3) ? flm_pkg::FLM_MEASURE : flm_pkg::FLM_EDIT});
        end
        check("exit_meas", measuring, 1'b1);
        apb(1'b0, 12'h030, 32'h0);
        check("unmapped", err_q, 1'b1);
        a = 2 * $urandom_range(100, 450);
        b = 2 * $urandom_range(100, 450);
        flow_in <= a[15:0];
        ticks(3);
        @(posedge pclk iff meas_tick === 1'b1);
        flow_in <= b[15:0];
        ticks(1);
        q = '{a, a, b};
        apb(1'b0, `FLM_ADDR_FLOW, 32'h0);
        check("flow_avg", rd_q, 32'((q[$] + q[$-1]) / 2));
        for (int i = 0; i < 4; i++) begin
            flow_in <= hf[i];
            temp_in <= ht[i];
            ticks(2);
            check("ls1", limit_switch_one, he[i][1]);
            check("ls2", limit_switch_two, he[i][0]);
        end
        apb(1'b1, `FLM_ADDR_SCALE, 32'd200);
        apb(1'b1, `FLM_ADDR_SCALE, 32'd1000);
        flow_in <= 16'd300;
        ticks(3);
        apb(1'b0, `FLM_ADDR_FLOW, 32'h0);
        check("scaled", rd_q, 32'd600);
        check("ls1_scaled", limit_switch_one, 1'b1);
        apb(1'b1, `FLM_ADDR_SCALE, 32'd100);
        flow_in <= 16'd4;
        ticks(3);
        apb(1'b0, `FLM_ADDR_FLOW, 32'h0);
        check("suppressed", rd_q, 32'd0);
        apb(1'b1, `FLM_ADDR_SUPP, 32'd0);
        check("supp_meas", measuring, 1'b1);
        apb(1'b0, `FLM_ADDR_OFFSET, 32'h0);
        check("offset", rd_q, 32'd4);
        for (int k = 4; k >= 0; k--) begin
            fault_in <= 12'((1 << (k + 1)) - 1);
            ticks(1);
            check("g3_num", error_number, g3[k]);
            check("g3_meas", measuring, 1'b1);
            check("g3_out", error_out, 1'b1);
        end
        apb(1'b0, `FLM_ADDR_ERRMEM, 32'h0);
        check("errmem", rd_q, 32'd41);
        fault_in <= 12'h000;
        ticks(1);
        check("no_err", error_number, 7'd0);
        apb(1'b1, `FLM_ADDR_CTRL, ctrl_cfg | 32'h10);
        apb(1'b0, `FLM_ADDR_ERRMEM, 32'h0);
        check("errmem_clr", rd_q, 32'd0);
        fault_in <= 12'h020;
        ticks(1);
        check("g2_num", error_number, 7'd21);
        check("g2_stop", measuring, 1'b0);
        fault_in <= 12'h070;
        ticks(1);
        check("g2_rank", error_number, 7'd10);
        fault_in <= 12'h000;
        ticks(1);
        check("g2_resume", measuring, 1'b1);
        for (int k = 11; k >= 7; k--) begin
            m = 12'((1 << (k + 1)) - (1 << 7)) | 12'h010;
            do_reset(m);
            check("g1_num", error_number, 7'(12 - k));
            check("g1_halt", measuring, 1'b0);
        end
        fault_in <= 12'h000;
        key_pressed <= 1'b1;
        repeat (6) @(posedge pclk);
        check("retest", selftest_busy, 1'b1);
        key_pressed <= 1'b0;
        wait_idle();
        check("retest_ok", measuring, 1'b1);
        tally_and_finish();
    end
endmodule : flm_flow_limit_error_test
bind flm_flow_limit_error flm_flow_limit_error_asserts i_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .meas_tick(meas_tick),
    .limit_switch_one(limit_switch_one), .limit_switch_two(limit_switch_two),
    .error_out(error_out), .selftest_busy(selftest_busy), .measuring(measuring),
    .error_number(error_number));
